//--- inc/tcc_cfg.svh
// Constants for the timer counter core: offsets, fields, resets.
// Included by the package, the core and the monitor; holds definitions only.
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_ADDR_W        8
`define TCC_OFS_CTRL      8'h20
`define TCC_OFS_CNTH      8'h21
`define TCC_OFS_CNTL      8'h22
`define TCC_OFS_LIMH      8'h23
`define TCC_OFS_LIML      8'h24
`define TCC_OFS_CH0       8'h25
`define TCC_OFS_CH1       8'h26

`define TCC_CTRL_FLAG     7
`define TCC_CTRL_IE       6
`define TCC_CTRL_HALT     5
`define TCC_CTRL_CLR      4
`define TCC_CTRL_PS_HI    2

`define TCC_CH_FLAG       7
`define TCC_CH_IE         6
`define TCC_CH_BUF        5
`define TCC_CH_CFG_W      6

`define TCC_PS_NONE       3'h7
`define TCC_LIMIT_RST     16'hffff
`define TCC_PSC_W         6

`endif

//--- inc/tcc_pkg.sv
// Types shared by the timer counter core.
// Assumes tcc_cfg.svh is on the include path.
`include "tcc_cfg.svh"

package tcc_pkg;

  typedef logic [7:0] tcc_byte_t;

  typedef struct packed {
    logic [15:0]            count;
    logic [`TCC_PSC_W-1:0]  psc;
    logic [15:0]            limit;
    logic                   limit_pend;
    logic                   wrap_flag;
    logic                   wrap_armed;
    logic                   wrap_irq_enable;
    logic                   count_halt;
    logic [2:0]             clock_divider_select;
    tcc_byte_t              low_latch;
    logic                   latched;
    logic [1:0]             channel_event_flag;
    logic [1:0]             ch_armed;
    logic [1:0]             channel_irq_enable;
    logic [`TCC_CH_CFG_W-1:0] ch0_cfg;
    logic [`TCC_CH_CFG_W-1:0] ch1_cfg;
    tcc_byte_t              rdata;
  } tcc_state_s;

endpackage

//--- logic/tcc_core.sv
// Timer counter core: prescaled 16-bit wrap counter, flags, registers.
// Assumes a synchronous byte register port and low-power and break
// levels from the system unit, all synchronous to mclk.
//
// Overview of operation
// RQ1 - Wrap flag sets when count reaches limit
// RQ2 - Wrap irq only when flag and enable set
// RQ3 - Channel events set flags, irq when enabled
// RQ4 - Wrap flag clears by read then write 0
// RQ5 - Wait: keep counting, refuse access, wake
// RQ6 - Stop mode freezes everything, keeps state; code freezes count and channel events, registers stay accessible
// RQ7 - Debug break freezes the counter
// RQ8 - Break protects flags unless clear enabled
// RQ9 - Per-channel mode; buffered only channel 0
// RQ10 - Halt bit stops count; reset sets it
// RQ11 - Clear bit zeroes count and prescaler
// RQ12 - Halt plus clear leaves count at zero
// RQ13 - Divider select 1..64, code 7 none
// RQ14 - High byte read latches low byte
// RQ15 - Count bytes read-only, cleared by reset
// RQ16 - Restart from zero after limit match
// RQ17 - Limit high write inhibits flag until low
// RQ18 - Reset sets limit to all ones
// RQ19 - Software clears count before new limit
// RQ20 - Software leaves count running before wait; bench writes the halt bit before raising wait_mode
// RQ21 - Channel flag clears by read then write 0
// RQ22 - 16-bit up-counter split into two bytes
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "tcc_cfg.svh"

module tcc_core (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic [`TCC_ADDR_W-1:0]       addr,
  input  wire tcc_pkg::tcc_byte_t           wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output tcc_pkg::tcc_byte_t                rdata,
  input  wire logic                         wait_mode,
  input  wire logic                         stop_mode,
  input  wire logic                         break_active,
  input  wire logic                         break_clear_enable,
  input  wire logic [1:0]                   channel_event,
  output logic                              wrap_irq,
  output logic [1:0]                        channel_irq,
  output logic                              wake_req,
  output logic                              count_tick,
  output logic [`TCC_CH_CFG_W-1:0]          ch0_cfg,
  output logic [`TCC_CH_CFG_W-1:0]          ch1_cfg
);
  import tcc_pkg::*;

  tcc_state_s s;
  tcc_state_s next_s;

  logic                  acc_wr;
  logic                  acc_rd;
  logic                  flag_guard;
  logic                  run;
  logic                  tick;
  logic                  match;
  logic [`TCC_PSC_W-1:0] psc_mask;
  logic [1:0]            ch_clear;

  // Register access is refused in wait mode
  assign acc_wr = wr & ~wait_mode; // RQ5
  assign acc_rd = rd & ~wait_mode; // RQ5
  // Protect two-step clears while in break without the enable
  assign flag_guard = break_active & ~break_clear_enable; // RQ8
  assign run = ~s.count_halt & ~stop_mode & ~break_active; // RQ6 RQ7 RQ10

  // Tick when the low prescaler bits are all ones
  always_comb begin
    psc_mask = '0;
    for (int i = 0; i < `TCC_PSC_W; i++) begin
      psc_mask[i] = (i < int'(s.clock_divider_select));
    end
  end
  assign tick = run && (s.clock_divider_select != `TCC_PS_NONE)
              && ((s.psc & psc_mask) == psc_mask); // RQ13
  assign match = (s.count == s.limit);

  always_comb begin
    next_s = s;
    ch_clear = 2'h0;
    // Prescaler only advances while the counter may run
    if (run) begin
      next_s.psc = s.psc + 1'b1; // RQ13
    end
    if (tick) begin
      if (match) begin
        next_s.count = 16'h0000; // RQ16
      end else begin
        next_s.count = s.count + 16'h0001; // RQ22
      end
    end

    // Read side effects
    if (acc_rd) begin
      case (addr)
        `TCC_OFS_CTRL: begin
          next_s.rdata = {s.wrap_flag, s.wrap_irq_enable,
                          s.count_halt, 1'b0, 1'b0,
                          s.clock_divider_select}; // RQ11
          if (s.wrap_flag && !flag_guard) begin
            next_s.wrap_armed = 1'b1; // RQ4 RQ8
          end
        end
        `TCC_OFS_CNTH: begin
          next_s.rdata = s.count[15:8];
          if (!s.latched) begin
            next_s.low_latch = s.count[7:0]; // RQ14
            next_s.latched = 1'b1;
          end
        end
        `TCC_OFS_CNTL: begin
          next_s.rdata = s.latched ? s.low_latch : s.count[7:0]; // RQ14
          next_s.latched = 1'b0;
        end
        `TCC_OFS_LIMH: next_s.rdata = s.limit[15:8];
        `TCC_OFS_LIML: next_s.rdata = s.limit[7:0];
        `TCC_OFS_CH0: begin
          next_s.rdata = {s.channel_event_flag[0],
                          s.channel_irq_enable[0], s.ch0_cfg};
          if (s.channel_event_flag[0] && !flag_guard) begin
            next_s.ch_armed[0] = 1'b1; // RQ21
          end
        end
        `TCC_OFS_CH1: begin
          next_s.rdata = {s.channel_event_flag[1],
                          s.channel_irq_enable[1], s.ch1_cfg};
          if (s.channel_event_flag[1] && !flag_guard) begin
            next_s.ch_armed[1] = 1'b1; // RQ21
          end
        end
        default: next_s.rdata = 8'h00;
      endcase
    end else begin
      next_s.rdata = 8'h00;
    end

    // Write side effects; count bytes ignore writes
    if (acc_wr) begin
      case (addr)
        `TCC_OFS_CTRL: begin
          next_s.wrap_irq_enable = wdata[`TCC_CTRL_IE];
          next_s.count_halt = wdata[`TCC_CTRL_HALT]; // RQ10
          next_s.clock_divider_select =
            wdata[`TCC_CTRL_PS_HI:0]; // RQ13
          if (!wdata[`TCC_CTRL_FLAG] && s.wrap_armed
              && !flag_guard) begin
            next_s.wrap_flag = 1'b0; // RQ4
            next_s.wrap_armed = 1'b0;
          end
          // Clear bit self-clears: it is never stored
          if (wdata[`TCC_CTRL_CLR]) begin
            next_s.count = 16'h0000; // RQ11 RQ12 RQ15
            next_s.psc = '0; // RQ11
          end
        end
        `TCC_OFS_LIMH: begin
          next_s.limit[15:8] = wdata;
          next_s.limit_pend = 1'b1; // RQ17
        end
        `TCC_OFS_LIML: begin
          next_s.limit[7:0] = wdata;
          next_s.limit_pend = 1'b0; // RQ17
        end
        `TCC_OFS_CH0: begin
          next_s.channel_irq_enable[0] = wdata[`TCC_CH_IE];
          next_s.ch0_cfg = wdata[`TCC_CH_CFG_W-1:0]; // RQ9
          ch_clear[0] = ~wdata[`TCC_CH_FLAG];
        end
        `TCC_OFS_CH1: begin
          next_s.channel_irq_enable[1] = wdata[`TCC_CH_IE];
          // Buffered mode exists only on channel 0
          next_s.ch1_cfg = {1'b0, wdata[`TCC_CH_BUF-1:0]}; // RQ9
          ch_clear[1] = ~wdata[`TCC_CH_FLAG];
        end
        default: ;
      endcase
    end

    // Channel clears, then events; an event wins and disarms
    for (int c = 0; c < 2; c++) begin
      if (ch_clear[c] && s.ch_armed[c] && !flag_guard) begin
        next_s.channel_event_flag[c] = 1'b0; // RQ21
        next_s.ch_armed[c] = 1'b0;
      end
      if (channel_event[c] && !stop_mode) begin
        next_s.channel_event_flag[c] = 1'b1; // RQ3
        next_s.ch_armed[c] = 1'b0; // RQ21
      end
    end

    // Wrap event wins over a pending clear
    if (tick && match && !s.limit_pend) begin
      next_s.wrap_flag = 1'b1; // RQ1 RQ17
      next_s.wrap_armed = 1'b0; // RQ4
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.count_halt <= 1'b1; // RQ10
      s.limit <= `TCC_LIMIT_RST; // RQ18
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign wrap_irq = s.wrap_flag & s.wrap_irq_enable
                  & ~s.limit_pend; // RQ2 RQ17
  assign channel_irq = s.channel_event_flag
                     & s.channel_irq_enable; // RQ3
  // Any enabled request may end wait mode
  assign wake_req = wait_mode & (wrap_irq | (|channel_irq)); // RQ5
  assign count_tick = tick;
  assign ch0_cfg = s.ch0_cfg;
  assign ch1_cfg = s.ch1_cfg;

endmodule

//--- verification/tcc_monitor.sv
// Checker for the timer counter core, bound to its ports.
// Assumes one clock, mclk, and rst as asynchronous reset.
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_monitor (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic [`TCC_ADDR_W-1:0] addr,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire tcc_pkg::tcc_byte_t     rdata,
  input wire logic                   wait_mode,
  input wire logic                   stop_mode,
  input wire logic                   break_active,
  input wire logic [1:0]             channel_event,
  input wire logic                   wrap_irq,
  input wire logic [1:0]             channel_irq,
  input wire logic                   wake_req,
  input wire logic                   count_tick
);
  import tcc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wake_path_a: assert property (
    wake_req == (wait_mode && (wrap_irq || |channel_irq)))
    else $error("wake request mismatch");
  wait_read_a: assert property (wait_mode && rd |=> rdata == 8'h00)
    else $error("read answered in wait");
  stop_freeze_a: assert property (stop_mode |-> !count_tick)
    else $error("tick in stop");
  break_freeze_a: assert property (break_active |-> !count_tick)
    else $error("tick in break");
  clear_reads_a: assert property (
    rd && !wait_mode && addr == `TCC_OFS_CTRL |=> !rdata[`TCC_CTRL_CLR])
    else $error("clear bit read as one");
  wrap_rise_a: assert property ($rose(wrap_irq) |-> $past(count_tick || wr))
    else $error("wrap irq rose without cause");
  wrap_fall_a: assert property ($fell(wrap_irq) |-> $past(wr))
    else $error("wrap irq fell without write");
  chan_rise_a: assert property (
    $rose(channel_irq[0]) |-> $past(channel_event[0] || wr))
    else $error("channel irq rose without cause");
  chan_fall_a: assert property ($fell(channel_irq[0]) |-> $past(wr))
    else $error("channel irq fell without write");
  cover property ($rose(wrap_irq));
  cover property (wake_req);
  cover property ($rose(channel_irq[0]));
endmodule

//--- verification/tcc_cpu_model.sv
// CPU side of the register port: one-cycle strobes, no wait states.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/1ps
module tcc_cpu_model (
  input  wire logic         mclk,
  output logic [7:0]        addr,
  output tcc_pkg::tcc_byte_t wdata,
  output logic              wr,
  output logic              rd,
  input  wire tcc_pkg::tcc_byte_t rdata
);
  import tcc_pkg::*;
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input tcc_byte_t v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output tcc_byte_t v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
endmodule

//--- verification/tb_tcc_core.sv
// Self-checking bench for the timer counter core.
// Assumes tcc_cpu_model drives the register port.
`timescale 1ns/1ps
module tb_tcc_core;
  import tcc_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, wr, rd, wrap_irq, wake_req, count_tick;
  logic wait_mode = 1'b0, stop_mode = 1'b0, break_active = 1'b0;
  logic break_clear_enable = 1'b0;
  logic [1:0] channel_event = 2'b00, channel_irq;
  logic [7:0] addr;
  tcc_byte_t wdata, rdata, d, l1;
  int miscompares = 0, checks_done = 0, n, c;
  always #25 mclk = ~mclk;
  tcc_cpu_model cpu_u (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  tcc_core dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .break_active(break_active),
    .break_clear_enable(break_clear_enable), .channel_event(channel_event),
    .wrap_irq(wrap_irq), .channel_irq(channel_irq), .wake_req(wake_req),
    .count_tick(count_tick), .ch0_cfg(), .ch1_cfg());
  task automatic chk(input string nm, input tcc_byte_t e, input tcc_byte_t g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input tcc_byte_t e);
    cpu_u.rd_reg(a, d);
    chk("register", e, d);
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Counts cycles to the next tick; a missing tick ends the run
  task automatic tick_gap();
    c = 0;
    do begin
      @(posedge mclk);
      #1 c++;
    end while (count_tick !== 1'b1 && c < 200);
    if (c == 200) begin
      miscompares++;
      results();
    end
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    results();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(8'h20, 8'h20);
    rd_chk(8'h23, 8'hff);
    rd_chk(8'h24, 8'hff);
    rd_chk(8'h21, 8'h00);
    rd_chk(8'h30, 8'h00);
    for (n = 0; n < 7; n++) begin
      cpu_u.wr_reg(8'h20, 8'h10 | 8'(n));
      tick_gap();
      tick_gap();
      chk("tick gap", 8'(1 << n), 8'(c));
    end
    cpu_u.wr_reg(8'h20, 8'h17);
    repeat (100) @(posedge mclk);
    rd_chk(8'h22, 8'h00);
    // Clear before the new limit so the count cannot sit past it
    cpu_u.wr_reg(8'h20, 8'h30);
    cpu_u.wr_reg(8'h23, 8'h00);
    cpu_u.wr_reg(8'h24, 8'h03);
    cpu_u.wr_reg(8'h20, 8'h50);
    repeat (8) @(posedge mclk);
    cpu_u.wr_reg(8'h20, 8'he0);
    rd_chk(8'h20, 8'he0);
    chk("wrap_irq", 8'h01, {7'h0, wrap_irq});
    @(posedge mclk) wait_mode <= 1'b1;
    cpu_u.wr_reg(8'h20, 8'h00);
    rd_chk(8'h20, 8'h00);
    chk("wake_req", 8'h01, {7'h0, wake_req});
    @(posedge mclk) wait_mode <= 1'b0;
    rd_chk(8'h20, 8'he0);
    cpu_u.wr_reg(8'h20, 8'h60);
    rd_chk(8'h20, 8'h60);
    chk("wrap_irq", 8'h00, {7'h0, wrap_irq});
    cpu_u.wr_reg(8'h23, 8'hff);
    cpu_u.wr_reg(8'h24, 8'hff);
    cpu_u.wr_reg(8'h20, 8'h10);
    cpu_u.rd_reg(8'h21, d);
    cpu_u.rd_reg(8'h21, d);
    cpu_u.rd_reg(8'h22, l1);
    cpu_u.rd_reg(8'h22, d);
    chk("latched low", d - 8'h06, l1);
    for (n = 0; n < 2; n++) begin
      @(posedge mclk) stop_mode <= (n == 0);
      break_active <= (n == 1);
      cpu_u.rd_reg(8'h22, l1);
      repeat (10) @(posedge mclk);
      rd_chk(8'h22, l1);
    end
    cpu_u.wr_reg(8'h25, 8'h40);
    @(posedge mclk) channel_event <= 2'b01;
    @(posedge mclk) channel_event <= 2'b00;
    #1 chk("channel_irq", 8'h01, {6'h0, channel_irq});
    rd_chk(8'h25, 8'hc0);
    cpu_u.wr_reg(8'h25, 8'h40);
    rd_chk(8'h25, 8'hc0);
    @(posedge mclk) break_active <= 1'b0;
    cpu_u.wr_reg(8'h25, 8'h40);
    rd_chk(8'h25, 8'hc0);
    cpu_u.wr_reg(8'h25, 8'h40);
    rd_chk(8'h25, 8'h40);
    cpu_u.wr_reg(8'h20, 8'h30);
    rd_chk(8'h22, 8'h00);
    cpu_u.wr_reg(8'h26, 8'h7f);
    rd_chk(8'h26, 8'h5f);
    results();
  end
endmodule
bind tcc_core tcc_monitor mon_u (.mclk(mclk), .rst(rst), .addr(addr),
  .wr(wr), .rd(rd), .rdata(rdata), .wait_mode(wait_mode),
  .stop_mode(stop_mode), .break_active(break_active),
  .channel_event(channel_event), .wrap_irq(wrap_irq),
  .channel_irq(channel_irq), .wake_req(wake_req), .count_tick(count_tick));
